// ---- hw/pfs_pkg.sv ----
// constants, register map and types of the pcm frame synchronizer
package pfs_pkg;

  // bus and datapath widths
  localparam int AW   = 4;   // register index width
  localparam int DW   = 32;  // register data width
  localparam int SW   = 33;  // widest sync word
  localparam int EW   = 6;   // sync error count width
  localparam int FLW  = 16;  // minor frame length width
  localparam int CNTW = 17;  // bit position counter width
  localparam int MFW  = 11;  // minor frames per major frame width
  localparam int CW   = 8;   // transition criterion width
  localparam int TW   = 6;   // tolerance width
  localparam int CTW  = 8;   // control register width
  localparam int NPIN = 6;   // sampled link pins

  // sync word length limits
  localparam logic [TW-1:0] SYNC_MIN = 6'h10;
  localparam logic [TW-1:0] SYNC_MAX = 6'h21;

  // register indices (one 32-bit word each)
  localparam logic [AW-1:0] REG_CTRL      = 4'h0;
  localparam logic [AW-1:0] REG_SYNC_LEN  = 4'h1;
  localparam logic [AW-1:0] REG_PAT_LO    = 4'h2;
  localparam logic [AW-1:0] REG_PAT_HI    = 4'h3;
  localparam logic [AW-1:0] REG_MASK_LO   = 4'h4;
  localparam logic [AW-1:0] REG_MASK_HI   = 4'h5;
  localparam logic [AW-1:0] REG_FRAME_LEN = 4'h6;
  localparam logic [AW-1:0] REG_MINORS    = 4'h7;
  localparam logic [AW-1:0] REG_TOL       = 4'h8;
  localparam logic [AW-1:0] REG_CRIT      = 4'h9;
  localparam logic [AW-1:0] REG_STATUS    = 4'hA;
  localparam logic [AW-1:0] REG_ERRS      = 4'hB;

  // control field positions
  localparam int CTRL_SRC    = 0;  // two bits
  localparam int CTRL_PH180  = 2;
  localparam int CTRL_DUAL   = 3;
  localparam int CTRL_AUTO   = 4;
  localparam int CTRL_MASKEN = 5;
  localparam int CTRL_DIS    = 6;
  localparam int CTRL_BURST  = 7;

  // tolerance, criteria and status field positions
  localparam int TOL_ERR  = 0;
  localparam int TOL_SLIP = 8;
  localparam int CRIT_S2C = 0;
  localparam int CRIT_C2L = 8;
  localparam int CRIT_L2C = 16;
  localparam int CRIT_C2S = 24;
  localparam int STAT_PH  = 4;
  localparam int STAT_IDX = 16;

  // stream source codes
  localparam logic [1:0] SRC_BITSYNC = 2'h0;
  localparam logic [1:0] SRC_EXT     = 2'h1;
  localparam logic [1:0] SRC_SIM     = 2'h2;

  // reported lock codes
  localparam logic [1:0] LOCK_SEARCH = 2'h0;
  localparam logic [1:0] LOCK_CHECK  = 2'h1;
  localparam logic [1:0] LOCK_LOCK   = 2'h2;

  // reset values
  localparam logic [CTW-1:0] RST_CTRL      = 8'h00;
  localparam logic [TW-1:0]  RST_SYNC_LEN  = 6'h20;
  localparam logic [SW-1:0]  RST_PATTERN   = 33'h0FE6B2840;
  localparam logic [SW-1:0]  RST_MASK      = 33'h000000000;
  localparam logic [FLW-1:0] RST_FRAME_LEN = 16'h0100;
  localparam logic [MFW-1:0] RST_MINORS    = 11'h001;

  // pin positions in the sampled vector
  localparam int PIN_BS_CLK  = 0;
  localparam int PIN_BS_DAT  = 1;
  localparam int PIN_EXT_CLK = 2;
  localparam int PIN_EXT_DAT = 3;
  localparam int PIN_SIM_CLK = 4;
  localparam int PIN_SIM_DAT = 5;

  typedef enum logic [1:0] {PFS_SEARCH, PFS_CHECK, PFS_LOCK} pfs_state_t;

endpackage

// ---- hw/pfs_frame_sync.sv ----
// pcm frame synchronizer with source select, sync search and lock tracking
`timescale 1ns/100ps

// Operation
// RL1: minor frames per major frame accepted from 1 to 1024.
// RL2: frame length counts sync bits; spacing runs sync word to sync word.
// RL3: sync word length 16 to 33 bits, comparator covers all.
// RL4: with masking on, mask ones exclude sync positions from comparison.
// RL5: each unmasked mismatching sync bit counts as one sync error.
// RL6: errors above tolerance fail the sync check and drive transitions.
// RL7: slips beyond the slip allowance count as failed checks.
// RL8: search-check-lock on good counts, lock-check-search on fail counts.
// RL9: lock state reported as 2 lock, 1 check, 0 search.
// RL10: data-in-search passes data in every lock state.
// RL11: burst mode delivers data as soon as sync is recognised.
// RL12: burst mode ignores frame length while sync keeps being detected.
// RL13: burst mode uses zero criteria; loss steps through check to search.
// RL14: exactly one of bit sync, external or simulator feeds the synchronizer.
// RL15: external source supplies both bit clock and serial data.
// RL16: simulator loopback feeds the bit sync path internally; here the simulator comes in on its own sim_clk and sim_data pins instead.
// RL17: external data sampled at 0 or 180 degrees of its clock.
// RL18: dual edge option captures a bit on each external clock edge.
// RL19: auto phase searches for the right external sampling phase.
// RL20: reset or config change restarts search with counters cleared.
// RL21: search compares every bit; check and lock only at frame spacing.
module pfs_frame_sync (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [pfs_pkg::AW-1:0] reg_addr,
  input  wire logic [pfs_pkg::DW-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [pfs_pkg::DW-1:0] reg_rdata,
  input  wire logic                  bs_clk,
  input  wire logic                  bs_data,
  input  wire logic                  ext_clk,
  input  wire logic                  ext_data,
  input  wire logic                  sim_clk,
  input  wire logic                  sim_data,
  output logic                       out_data,
  output logic                       out_valid,
  output logic                       out_frame_start,
  output logic                       out_major_start,
  output logic      [1:0]            frame_lock_state,
  output logic      [pfs_pkg::MFW-1:0] minor_index
);
  import pfs_pkg::*;

  // register index match
  function automatic logic pfs_hit(input logic [AW-1:0] a, input logic [AW-1:0] idx);
    return a == idx;
  endfunction

  // number of set bits in a sync window
  function automatic logic [EW-1:0] pfs_ones(input logic [SW-1:0] v);
    logic [EW-1:0] n;
    n = '0;
    for (int i = 0; i < SW; i++)
    begin
      n = n + EW'(v[i]);
    end
    return n;
  endfunction

  // report code of a lock state
  function automatic logic [1:0] pfs_code(input pfs_state_t s);
    case (s)
      PFS_LOCK:  return LOCK_LOCK;
      PFS_CHECK: return LOCK_CHECK;
      default:   return LOCK_SEARCH;
    endcase
  endfunction

  logic [CTW-1:0]  ctrl;
  logic [TW-1:0]   sync_len;
  logic [SW-1:0]   pattern;
  logic [SW-1:0]   mask;
  logic [FLW-1:0]  frame_len;
  logic [MFW-1:0]  minors;
  logic [TW-1:0]   err_tol;
  logic [TW-1:0]   slip_tol;
  logic [DW-1:0]   crit;
  logic            restart;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_f;
  logic            clk_prev;
  logic            auto_phase;
  logic [CNTW-1:0] hunt;
  logic [SW-1:0]   shreg;
  logic [CNTW-1:0] cnt;
  logic [CW-1:0]   good;
  logic [CW-1:0]   bad;
  pfs_state_t      state;
  logic [EW-1:0]   err_last;

  // write decode
  wire wr_ctrl  = reg_wr && pfs_hit(reg_addr, REG_CTRL);
  wire wr_slen  = reg_wr && pfs_hit(reg_addr, REG_SYNC_LEN);
  wire wr_plo   = reg_wr && pfs_hit(reg_addr, REG_PAT_LO);
  wire wr_phi   = reg_wr && pfs_hit(reg_addr, REG_PAT_HI);
  wire wr_mlo   = reg_wr && pfs_hit(reg_addr, REG_MASK_LO);
  wire wr_mhi   = reg_wr && pfs_hit(reg_addr, REG_MASK_HI);
  wire wr_flen  = reg_wr && pfs_hit(reg_addr, REG_FRAME_LEN);
  wire wr_minor = reg_wr && pfs_hit(reg_addr, REG_MINORS);
  wire wr_tol   = reg_wr && pfs_hit(reg_addr, REG_TOL);
  wire wr_crit  = reg_wr && pfs_hit(reg_addr, REG_CRIT);

  // sync length written out of range is clamped into 16..33
  wire [TW-1:0] slen_in  = reg_wdata[TW-1:0];
  wire [TW-1:0] slen_lim = (reg_wdata[DW-1:TW] != '0 || slen_in > SYNC_MAX) ? SYNC_MAX :
                           (slen_in < SYNC_MIN) ? SYNC_MIN : slen_in; // RL3

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl      <= RST_CTRL;
      sync_len  <= RST_SYNC_LEN;
      pattern   <= RST_PATTERN;
      mask      <= RST_MASK;
      frame_len <= RST_FRAME_LEN;
      minors    <= RST_MINORS;
      err_tol   <= '0;
      slip_tol  <= '0;
      crit      <= '0;
    end
    else
    begin
      if (wr_ctrl)  ctrl <= reg_wdata[CTW-1:0];
      if (wr_slen)  sync_len <= slen_lim;
      if (wr_plo)   pattern[DW-1:0] <= reg_wdata;
      if (wr_phi)   pattern[SW-1] <= reg_wdata[0];
      if (wr_mlo)   mask[DW-1:0] <= reg_wdata;
      if (wr_mhi)   mask[SW-1] <= reg_wdata[0];
      if (wr_flen)  frame_len <= reg_wdata[FLW-1:0]; // RL2
      if (wr_minor) minors <= reg_wdata[MFW-1:0]; // RL1
      if (wr_tol)   err_tol <= reg_wdata[TOL_ERR +: TW];
      if (wr_tol)   slip_tol <= reg_wdata[TOL_SLIP +: TW];
      if (wr_crit)  crit <= reg_wdata;
    end
  end

  // any configuration write restarts the search one cycle later
  always_ff @(posedge clk)
  begin
    restart <= !srst && reg_wr; // RL20
  end

  // three-stage sampling of link pins, a change counts when stages 2 and 3 agree
  assign pin_raw = {sim_data, sim_clk, ext_data, ext_clk, bs_data, bs_clk};
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f  <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
    end
  end

  // source selection, code 3 falls back to the bit sync
  wire [1:0] src     = ctrl[CTRL_SRC +: 2];
  wire       sel_ext = (src == SRC_EXT);
  wire       sel_sim = (src == SRC_SIM);
  wire       src_clk = sel_ext ? pin_f[PIN_EXT_CLK] :
                       sel_sim ? pin_f[PIN_SIM_CLK] : pin_f[PIN_BS_CLK]; // RL14 RL16
  wire       src_dat = sel_ext ? pin_f[PIN_EXT_DAT] :
                       sel_sim ? pin_f[PIN_SIM_DAT] : pin_f[PIN_BS_DAT]; // RL14 RL15

  // edge finding and bit capture
  wire burst    = ctrl[CTRL_BURST];
  wire rise     = src_clk && !clk_prev;
  wire fall     = !src_clk && clk_prev;
  wire ph_eff   = ctrl[CTRL_AUTO] ? auto_phase : ctrl[CTRL_PH180]; // RL19
  wire ext_take = ctrl[CTRL_DUAL] ? (rise || fall) : // RL18
                  ph_eff ? fall : rise; // RL17
  wire take     = sel_ext ? ext_take : rise;

  always_ff @(posedge clk)
  begin
    if (srst)
      clk_prev <= 1'b0;
    else
      clk_prev <= src_clk;
  end

  // sync window comparison
  logic [SW-1:0] len_mask;
  genvar g;
  generate
    for (g = 0; g < SW; g++)
    begin : g_len
      assign len_mask[g] = (g < int'(sync_len)); // RL3
    end
  endgenerate

  wire [SW-1:0]   next_shreg = {shreg[SW-2:0], src_dat};
  wire [SW-1:0]   cmp_mask   = ctrl[CTRL_MASKEN] ? ~mask : '1; // RL4
  wire [SW-1:0]   diff       = (next_shreg ^ pattern) & len_mask & cmp_mask;
  wire [EW-1:0]   errs       = pfs_ones(diff); // RL5
  wire            match      = (errs <= EW'(err_tol)); // RL6
  wire [CNTW-1:0] cnt_inc    = cnt + CNTW'(1);
  wire [CNTW-1:0] flen_w     = CNTW'(frame_len);
  wire [CNTW-1:0] slip_w     = CNTW'(slip_tol);
  wire [CNTW-1:0] win_lo     = burst ? CNTW'(1) : // RL12
                               (slip_w >= flen_w) ? CNTW'(1) : flen_w - slip_w; // RL7
  wire [CNTW-1:0] win_hi     = flen_w + slip_w; // RL7

  // criteria, all zero in burst mode
  wire [CW-1:0] c_s2c = burst ? '0 : crit[CRIT_S2C +: CW]; // RL13
  wire [CW-1:0] c_c2l = burst ? '0 : crit[CRIT_C2L +: CW]; // RL13
  wire [CW-1:0] c_l2c = burst ? '0 : crit[CRIT_L2C +: CW];
  wire [CW-1:0] c_c2s = burst ? '0 : crit[CRIT_C2S +: CW];

  // lock state machine next values
  pfs_state_t      next_state;
  logic [CW-1:0]   next_good;
  logic [CW-1:0]   next_bad;
  logic [CNTW-1:0] next_cnt;
  logic            sync_ok;
  logic            eval;
  always_comb
  begin
    next_state = state;
    next_good  = good;
    next_bad   = bad;
    next_cnt   = cnt;
    sync_ok    = 1'b0;
    eval       = 1'b0;
    if (take)
    begin
      next_cnt = cnt_inc;
      case (state)
        PFS_SEARCH:
        begin
          if (match) // RL21
          begin
            sync_ok  = 1'b1;
            next_cnt = '0;
            if (good >= c_s2c) // RL8
            begin
              next_state = PFS_CHECK;
              next_good  = '0;
            end
            else
              next_good = good + CW'(1);
          end
        end
        PFS_CHECK, PFS_LOCK:
        begin
          if (match && cnt_inc >= win_lo) // RL21
          begin
            sync_ok  = 1'b1;
            eval     = 1'b1;
            next_cnt = '0;
            next_bad = '0;
            if (state == PFS_CHECK && good >= c_c2l) // RL8
            begin
              next_state = PFS_LOCK;
              next_good  = '0;
            end
            else if (state == PFS_CHECK)
              next_good = good + CW'(1);
          end
          else if (cnt_inc >= win_hi) // RL7
          begin
            eval      = 1'b1;
            next_cnt  = cnt_inc - flen_w;
            next_good = '0;
            if (state == PFS_LOCK && bad >= c_l2c) // RL8 RL13
            begin
              next_state = PFS_CHECK;
              next_bad   = '0;
            end
            else if (state == PFS_CHECK && bad >= c_c2s) // RL8 RL13
            begin
              next_state = PFS_SEARCH;
              next_bad   = '0;
            end
            else
              next_bad = bad + CW'(1); // RL6
          end
        end
        default:
          next_state = PFS_SEARCH;
      endcase
    end
  end

  // lock state and counters
  always_ff @(posedge clk)
  begin
    if (srst || restart) // RL20
    begin
      state <= PFS_SEARCH;
      good  <= '0;
      bad   <= '0;
      cnt   <= '0;
      shreg <= '0;
    end
    else
    begin
      state <= next_state;
      good  <= next_good;
      bad   <= next_bad;
      cnt   <= next_cnt;
      if (take)
        shreg <= next_shreg;
    end
  end

  // error count of the last frame-spaced check
  always_ff @(posedge clk)
  begin
    if (srst || restart)
      err_last <= '0;
    else if (eval)
      err_last <= errs;
  end

  // auto phase flips the external sampling edge after two frames without sync
  wire hunt_on  = sel_ext && ctrl[CTRL_AUTO] && state == PFS_SEARCH && take;
  wire hunt_end = (hunt + CNTW'(1)) >= (flen_w << 1);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      auto_phase <= 1'b0;
      hunt       <= '0;
    end
    else if (restart)
    begin
      auto_phase <= ctrl[CTRL_PH180];
      hunt       <= '0;
    end
    else if (hunt_on)
    begin
      hunt       <= (match || hunt_end) ? '0 : hunt + CNTW'(1);
      auto_phase <= (!match && hunt_end) ? !auto_phase : auto_phase; // RL19
    end
  end

  // delivery decision on the state being entered
  wire deliver = (next_state == PFS_LOCK) || ctrl[CTRL_DIS] || // RL10
                 (burst && next_state != PFS_SEARCH); // RL11
  wire idx_wrap = (MFW'(minor_index + MFW'(1)) >= minors) ||
                  (minor_index == {MFW{1'b1}}); // RL1

  // stream outputs
  always_ff @(posedge clk)
  begin
    if (srst || restart)
    begin
      out_data         <= 1'b0;
      out_valid        <= 1'b0;
      out_frame_start  <= 1'b0;
      out_major_start  <= 1'b0;
      frame_lock_state <= LOCK_SEARCH;
      minor_index      <= '0;
    end
    else
    begin
      out_data         <= take ? src_dat : out_data;
      out_valid        <= take && deliver;
      out_frame_start  <= sync_ok && deliver;
      out_major_start  <= sync_ok && deliver && (state == PFS_SEARCH || idx_wrap);
      frame_lock_state <= pfs_code(next_state); // RL9
      if (sync_ok && state == PFS_SEARCH)
        minor_index <= '0;
      else if (sync_ok)
        minor_index <= idx_wrap ? '0 : minor_index + MFW'(1);
    end
  end

  // read selection
  logic [DW-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    case (reg_addr)
      REG_CTRL:      rd_mux = DW'(ctrl);
      REG_SYNC_LEN:  rd_mux = DW'(sync_len);
      REG_PAT_LO:    rd_mux = pattern[DW-1:0];
      REG_PAT_HI:    rd_mux = DW'(pattern[SW-1]);
      REG_MASK_LO:   rd_mux = mask[DW-1:0];
      REG_MASK_HI:   rd_mux = DW'(mask[SW-1]);
      REG_FRAME_LEN: rd_mux = DW'(frame_len);
      REG_MINORS:    rd_mux = DW'(minors);
      REG_TOL:       rd_mux = DW'({slip_tol, 2'h0, err_tol});
      REG_CRIT:      rd_mux = crit;
      REG_STATUS:    rd_mux = (DW'(minor_index) << STAT_IDX) | (DW'(ph_eff) << STAT_PH) |
                              DW'(frame_lock_state);
      REG_ERRS:      rd_mux = DW'(err_last);
      default:       rd_mux = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else
      reg_rdata <= reg_rd ? rd_mux : '0;
  end

endmodule // pfs_frame_sync

// ---- testbench/pfs_frame_sync_props.sv ----
// port checker for the pcm frame synchronizer, bound to its top module
`timescale 1ns/100ps
module pfs_frame_sync_props (
  input wire logic                    clk,
  input wire logic                    srst,
  input wire logic [pfs_pkg::AW-1:0]  reg_addr,
  input wire logic [pfs_pkg::DW-1:0]  reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [pfs_pkg::DW-1:0]  reg_rdata,
  input wire logic                    out_valid,
  input wire logic                    out_frame_start,
  input wire logic                    out_major_start,
  input wire logic [1:0]              frame_lock_state,
  input wire logic [pfs_pkg::MFW-1:0] minor_index
);
  import pfs_pkg::*;
  logic [CTW-1:0]      ctl;
  logic [MFW-1:0]      mnr;
  logic [2:0]          wr_hist;
  wire logic           quiet   = (wr_hist == 3'h0);
  wire logic [MFW-1:0] mnr_eff = (mnr == 11'h000) ? 11'h001 : mnr;

  // shadow of the settings that shape delivery; recent writes restart the block
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctl <= RST_CTRL;
      mnr <= RST_MINORS;
      wr_hist <= 3'h0;
    end
    else
    begin
      wr_hist <= {wr_hist[1:0], reg_wr};
      if (reg_wr && reg_addr == REG_CTRL) ctl <= reg_wdata[CTW-1:0];
      if (reg_wr && reg_addr == REG_MINORS) mnr <= reg_wdata[MFW-1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // lock code, state steps and restart
  lock_code_a: assert property (frame_lock_state != 2'h3)
    else $error("lock code out of range");
  status_read_a: assert property (reg_rd && reg_addr == REG_STATUS |=>
    reg_rdata[1:0] == $past(frame_lock_state) && reg_rdata[26:16] == $past(minor_index))
    else $error("status read disagrees with lock outputs");
  lock_entry_a: assert property ($changed(frame_lock_state) &&
    frame_lock_state == LOCK_LOCK |-> $past(frame_lock_state) == LOCK_CHECK)
    else $error("lock entered other than from check");
  search_exit_a: assert property ($past(frame_lock_state) == LOCK_SEARCH |->
    frame_lock_state != LOCK_LOCK) else $error("search jumped to lock");
  restart_a: assert property (reg_wr |-> ##[1:3] frame_lock_state == LOCK_SEARCH)
    else $error("write did not restart search");
  // delivery and frame marks
  start_bit_a: assert property (out_frame_start |-> out_valid)
    else $error("frame start without a delivered bit");
  major_start_a: assert property (out_major_start |->
    out_frame_start && minor_index == 11'h000) else $error("major start misplaced");
  minor_range_a: assert property (out_frame_start && quiet |-> minor_index < mnr_eff)
    else $error("minor index beyond frame count");
  lock_only_a: assert property (out_valid && quiet && !ctl[CTRL_DIS] && !ctl[CTRL_BURST]
    |-> frame_lock_state == LOCK_LOCK)
    else $error("data delivered outside lock");

  cover property (out_frame_start && frame_lock_state == LOCK_LOCK);
  cover property (out_major_start);
  cover property (out_valid && frame_lock_state == LOCK_CHECK);
endmodule // pfs_frame_sync_props

bind pfs_frame_sync pfs_frame_sync_props u_props (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_valid(out_valid),
  .out_frame_start(out_frame_start), .out_major_start(out_major_start),
  .frame_lock_state(frame_lock_state), .minor_index(minor_index));

// ---- testbench/pfs_pcm_src.sv ----
// telemetry source model driving one serial bit clock and data pair
`timescale 1ns/100ps
module pfs_pcm_src (
  output logic pclk,
  output logic pdat
);
  // clock idles low between frames
  initial
  begin
    pclk = 1'b0;
    pdat = 1'b0;
  end

  // clock period 160 ns, a bit per edge in dual mode; data settles before the capture edge
  task automatic send(input logic b[$], input logic ph, input logic dual);
    #3; // keep pin changes off the bench clock edges
    foreach (b[i])
    begin
      if (dual)
      begin
        pdat = b[i];
        #40 pclk = ~pclk;
        #40;
      end
      else if (ph)
      begin
        pclk = 1'b1;
        #40 pdat = b[i];
        #80 pclk = 1'b0;
        #40;
      end
      else
      begin
        pdat = b[i];
        #80 pclk = 1'b1;
        #80 pclk = 1'b0;
      end
    end
    pdat = ~pdat; // stream over: line no longer holds the last bit
  endtask
endmodule // pfs_pcm_src

// ---- testbench/pfs_frame_sync_tb_top.sv ----
// self-checking testbench of the pcm frame synchronizer
`timescale 1ns/100ps
module pfs_frame_sync_tb_top;
  import pfs_pkg::*;
  logic           clk, srst, reg_wr, reg_rd, rd_d, pclk, pdat;
  logic           out_data, out_valid, out_frame_start, out_major_start;
  logic [AW-1:0]  reg_addr;
  logic [DW-1:0]  reg_wdata, reg_rdata;
  logic [1:0]     frame_lock_state, sel;
  logic [MFW-1:0] minor_index;
  logic [31:0]    rnd = 32'hD762;
  logic [63:0]    rd_q[$], n;
  logic [1:0]     bit_q[$];
  int             bad_count = 0, n_compared = 0, cyc = 0;
  // the chosen source gets the stream, the others its complement
  wire logic bs_data  = (sel == SRC_BITSYNC || sel == 2'h3) ? pdat : ~pdat;
  wire logic ext_data = (sel == SRC_EXT) ? pdat : ~pdat;
  wire logic sim_data = (sel == SRC_SIM) ? pdat : ~pdat;

  pfs_pcm_src pcm (.pclk(pclk), .pdat(pdat));
  pfs_frame_sync DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bs_clk(pclk),
    .bs_data(bs_data), .ext_clk(pclk), .ext_data(ext_data), .sim_clk(pclk),
    .sim_data(sim_data), .out_data(out_data), .out_valid(out_valid),
    .out_frame_start(out_frame_start), .out_major_start(out_major_start),
    .frame_lock_state(frame_lock_state), .minor_index(minor_index));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // delivered stream bit with its frame start flag
  task automatic cmp_bit(input logic [1:0] e, input logic [1:0] s);
    cmp("out_bit", {30'h0, e}, {30'h0, s});
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read with the expected value noted under a field mask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [DW-1:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back({m, e & m});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // configure, build frames, note every bit due out, then stream them
  task automatic run(input logic [1:0] s, input logic [7:0] ctl, input logic [5:0] sl,
    input logic [32:0] pat, input logic [32:0] msk, input logic [5:0] tol,
    input logic [32:0] flip, input logic [7:0] badf, input int nf, input int fl);
    logic        b[$];
    logic [32:0] sw, lm;
    logic        g, v;
    int          st, e, len;
    sel <= s;
    wr(REG_CTRL, {24'h0, ctl[7:2], s});
    wr(REG_SYNC_LEN, {26'h0, sl});
    wr(REG_PAT_LO, pat[31:0]);
    wr(REG_PAT_HI, {31'h0, pat[32]});
    wr(REG_MASK_LO, msk[31:0]);
    wr(REG_MASK_HI, {31'h0, msk[32]});
    wr(REG_FRAME_LEN, 32'h40);
    wr(REG_TOL, {26'h0, tol});
    wr(REG_CRIT, 32'h0);
    wr(4'hF, rnd);
    rd(REG_STATUS, 32'h0, 32'h3);
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    lm = 33'h1FFFFFFFF >> (6'h21 - sl);
    st = 0;
    for (int k = 0; k < nf; k++)
    begin
      len = (ctl[CTRL_BURST] && !badf[k]) ? fl : 64;
      sw = badf[k] ? pat ^ flip : pat;
      e = $countones((sw ^ pat) & lm & (ctl[CTRL_MASKEN] ? ~msk : 33'h1FFFFFFFF));
      g = (e <= tol);
      for (int i = 0; i < len; i++)
      begin
        if (i < sl)
          v = sw[sl-1-i];
        else
        begin
          rnd = lfsr(rnd);
          v = rnd[0];
        end
        b.push_back(v);
        if (i == sl - 1) st = g ? (st == 2 ? 2 : st + 1) : (st == 0 ? 0 : st - 1);
        if (ctl[CTRL_DIS] || st == 2 || (ctl[CTRL_BURST] && st != 0))
          bit_q.push_back({g && i == sl - 1, v});
      end
    end
    pcm.send(b, ctl[CTRL_PH180], ctl[CTRL_DUAL]);
    repeat (40) @(posedge clk);
    cmp("bits left", 32'h0, bit_q.size());
    rd(REG_STATUS, {27'h0, ctl[CTRL_PH180], 2'h0, st[1:0]}, 32'h13);
    rd(REG_ERRS, e, 32'h3F);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // compare each read slot and each delivered bit against the oldest note
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (rd_d === 1'b1)
    begin
      n = rd_q.pop_front();
      cmp("reg_rdata", n[31:0], reg_rdata & n[63:32]);
    end
    if (out_valid !== 1'b0)
    begin
      if (bit_q.size() == 0)
        cmp("out_valid", 32'h0, {31'h0, out_valid});
      else
        cmp_bit(bit_q.pop_front(), {out_frame_start, out_data});
    end
    if (cyc == 90000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    sel = SRC_BITSYNC;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(REG_CTRL, 32'h0, 32'hFF);
    rd(REG_SYNC_LEN, 32'h20, 32'h3F);
    rd(REG_PAT_LO, 32'hFE6B2840, 32'hFFFFFFFF);
    rd(REG_FRAME_LEN, 32'h100, 32'hFFFF);
    rd(REG_MINORS, 32'h1, 32'h7FF);
    wr(REG_MINORS, 32'h400);
    rd(REG_MINORS, 32'h400, 32'h7FF);
    run(SRC_EXT, 8'h00, 6'h20, 33'h0FE6B2840, 33'h0, 6'h0, 33'h0, 8'h00, 4, 64);
    run(SRC_BITSYNC, 8'h00, 6'h10, 33'h0EB90, 33'h0, 6'h1, 33'h1, 8'h08, 4, 64);
    run(SRC_SIM, 8'h00, 6'h21, 33'h1F0E2D3C4, 33'h0, 6'h2, 33'h70, 8'h04, 5, 64);
    run(SRC_EXT, 8'h34, 6'h20, 33'h0FE6B2840, 33'hF000, 6'h0, 33'h9000, 8'h06, 4, 64);
    run(SRC_EXT, 8'h48, 6'h18, 33'h0FAF320, 33'h0, 6'h0, 33'h1, 8'h04, 4, 64);
    run(2'h3, 8'h80, 6'h18, 33'h0FAF320, 33'h0, 6'h0, 33'h30, 8'h04, 6, 48);
    final_report();
  end
endmodule // pfs_frame_sync_tb_top
